/* hw/oscc_map.vh */
// Register offsets, field positions, reset values and timing constants of the soft control block.
`ifndef OSCC_MAP_VH
`define OSCC_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OSCC_CTRL_OFS       8'h00
`define OSCC_STATUS_OFS     8'h04
`define OSCC_IRQ_STAT_OFS   8'h08
`define OSCC_IRQ_MASK_OFS   8'h0C
`define OSCC_BIAS_OFS       8'h10
`define OSCC_MOD_OFS        8'h14
`define OSCC_MON_OFS        8'h18
`define OSCC_MON_FS_OFS     8'h1C
`define OSCC_NVW_OFS        8'h20

// ----------------------------------------------------------------
// Control fields (the soft transmit-disable bit sits at bit 6)
// ----------------------------------------------------------------
`define OSCC_CTRL_RATE_BIT  3
`define OSCC_CTRL_TXD_BIT   6
`define OSCC_CTRL_RST       8'h00

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define OSCC_ST_TXF_BIT     0
`define OSCC_ST_LOS_BIT     1
`define OSCC_ST_RATE_BIT    2
`define OSCC_ST_INIT_BIT    3
`define OSCC_ST_NVW_BIT     4
`define OSCC_ST_DIS_BIT     5

// ----------------------------------------------------------------
// Interrupt fields
// ----------------------------------------------------------------
`define OSCC_IRQ_TXF_BIT    0
`define OSCC_IRQ_LOS_BIT    1
`define OSCC_IRQ_LOSC_BIT   2
`define OSCC_IRQ_INIT_BIT   3
`define OSCC_IRQ_NVW_BIT    4
`define OSCC_IRQ_W          5

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define OSCC_DAC_RST        8'h00
`define OSCC_MON_FS_RST     12'hFFF

// ----------------------------------------------------------------
// Timing, in the unit stated by each name
// ----------------------------------------------------------------
`define OSCC_CLK_HZ         20000000
`define OSCC_T_OFF_MS       10
`define OSCC_T_ON_MS        50
`define OSCC_T_INIT_MS      200
`define OSCC_T_FAULT_MS     50
`define OSCC_T_LOS_MS       50
`define OSCC_T_RATE_MS      50
`define OSCC_T_NVW_MS       20
`define OSCC_MS_CYC         (`OSCC_CLK_HZ / 1000)
`define OSCC_STEP_US        10
`define OSCC_STEP_CYC       ((`OSCC_CLK_HZ / 1000000) * `OSCC_STEP_US)
`define OSCC_INIT_CYC       (`OSCC_T_INIT_MS / 2 * `OSCC_MS_CYC)
`define OSCC_NVW_CYC        (`OSCC_T_NVW_MS / 2 * `OSCC_MS_CYC)
`define OSCC_LOS_FILT_CYC   (`OSCC_T_LOS_MS / 5 * `OSCC_MS_CYC)

`endif

/* hw/oscc_ramp.v */
// Current sink output ramp with off state and no overshoot.
`timescale 1ns/1ps

module oscc_ramp #(
    parameter W = 8
) (
    clk,
    resetn,
    step_en,
    disable_i,
    target,
    level,
    drive_en
);
    input  wire         clk;
    input  wire         resetn;
    input  wire         step_en;
    input  wire         disable_i;
    input  wire [W-1:0] target;
    output reg  [W-1:0] level;
    output reg          drive_en;

    always @(posedge clk) begin
        if (!resetn) begin
            level    <= {W{1'b0}};
            drive_en <= 1'b0;
        end else if (disable_i) begin
            // Off at once: level snaps to zero so the next enable ramps from zero.
            level    <= {W{1'b0}};
            drive_en <= 1'b0;
        end else begin
            drive_en <= 1'b1;
            if (level > target) begin
                level <= target;
            end else if (step_en && level != target) begin
                level <= level + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // oscc_ramp

/* hw/oscc_top.v */
// Soft control and status block of an optical module controller, with Wishbone registers.
//
// The register offsets and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`include "oscc_map.vh"

module oscc_top #(
    parameter DAC_W    = 8,
    parameter MON_W    = 12,
    parameter INIT_CYC = `OSCC_INIT_CYC,
    parameter NVW_CYC  = `OSCC_NVW_CYC,
    parameter LOS_CYC  = `OSCC_LOS_FILT_CYC,
    parameter STEP_CYC = `OSCC_STEP_CYC
) (
    clk,
    resetn,
    wb_cyc_i,
    wb_stb_i,
    wb_we_i,
    wb_adr_i,
    wb_sel_i,
    wb_dat_i,
    wb_dat_o,
    wb_ack_o,
    irq,
    transmit_disable_pin,
    fault_in,
    signal_lost_in,
    scl_in,
    monitor_input,
    bias_current_sink,
    bias_sink_en,
    modulation_current_sink,
    modulation_sink_en,
    transmit_fault_oe,
    receive_signal_lost_oe,
    rate_select_output_oe,
    serial_busy
);
    input  wire             clk;
    input  wire             resetn;
    input  wire             wb_cyc_i;
    input  wire             wb_stb_i;
    input  wire             wb_we_i;
    input  wire [7:0]       wb_adr_i;
    input  wire [3:0]       wb_sel_i;
    input  wire [31:0]      wb_dat_i;
    output reg  [31:0]      wb_dat_o;
    output reg              wb_ack_o;
    output wire             irq;
    input  wire             transmit_disable_pin;
    input  wire             fault_in;
    input  wire             signal_lost_in;
    input  wire             scl_in;
    input  wire [MON_W:0]   monitor_input;
    output wire [DAC_W-1:0] bias_current_sink;
    output wire             bias_sink_en;
    output wire [DAC_W-1:0] modulation_current_sink;
    output wire             modulation_sink_en;
    output reg              transmit_fault_oe;
    output reg              receive_signal_lost_oe;
    output reg              rate_select_output_oe;
    output wire             serial_busy;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg [1:0] txd_s_r;
    reg [1:0] flt_s_r;
    reg [1:0] los_s_r;
    reg [1:0] scl_s_r;
    reg       scl_d_r;

    always @(posedge clk) begin
        if (!resetn) begin
            txd_s_r <= 2'b00;
            flt_s_r <= 2'b00;
            los_s_r <= 2'b00;
            scl_s_r <= 2'b11;
            scl_d_r <= 1'b1;
        end else begin
            txd_s_r <= {txd_s_r[0], transmit_disable_pin};
            flt_s_r <= {flt_s_r[0], fault_in};
            los_s_r <= {los_s_r[0], signal_lost_in};
            scl_s_r <= {scl_s_r[0], scl_in};
            scl_d_r <= scl_s_r[1];
        end
    end

    wire txd_pin  = txd_s_r[1];
    wire scl_fall = scl_d_r & ~scl_s_r[1];

    // ----------------------------------------------------------------
    // Registers and bus slave
    // ----------------------------------------------------------------
    reg [7:0]          ctrl_r;
    reg [7:0]          pend_ctrl_r;
    reg                pend_r;
    reg [DAC_W-1:0]    bias_r;
    reg [DAC_W-1:0]    mod_r;
    reg [MON_W-1:0]    mon_fs_r;
    reg [MON_W-1:0]    mon_r;
    reg [`OSCC_IRQ_W-1:0] ist_r;
    reg [`OSCC_IRQ_W-1:0] imask_r;
    reg                nvw_req_r;
    reg                init_done_r;
    reg                nvw_busy_r;
    reg                los_r;
    reg [`OSCC_IRQ_W-1:0] ev_set;

    wire acc      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr       = acc & wb_we_i & wb_sel_i[0];
    wire blocked  = nvw_busy_r | ~init_done_r;
    wire wr_ok    = wr & ~blocked;

    assign serial_busy = blocked;

    always @(posedge clk) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= acc;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            wb_dat_o <= 32'h00000000;
        end else if (acc) begin
            case (wb_adr_i)
                `OSCC_CTRL_OFS:     wb_dat_o <= {24'h000000, ctrl_r};
                `OSCC_STATUS_OFS:   wb_dat_o <= {26'h0000000, ~bias_sink_en, nvw_busy_r,
                                                 init_done_r, rate_select_output_oe,
                                                 los_r, transmit_fault_oe};
                `OSCC_IRQ_STAT_OFS: wb_dat_o <= {27'h0000000, ist_r};
                `OSCC_IRQ_MASK_OFS: wb_dat_o <= {27'h0000000, imask_r};
                `OSCC_BIAS_OFS:     wb_dat_o <= {24'h000000, bias_r};
                `OSCC_MOD_OFS:      wb_dat_o <= {24'h000000, mod_r};
                `OSCC_MON_OFS:      wb_dat_o <= {20'h00000, mon_r};
                `OSCC_MON_FS_OFS:   wb_dat_o <= {20'h00000, mon_fs_r};
                default:            wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Control writes are held until the serial-clock fall after the stop,
    // modelled here as the first synchronised scl fall after the bus write.
    always @(posedge clk) begin
        if (!resetn) begin
            ctrl_r      <= `OSCC_CTRL_RST;
            pend_ctrl_r <= `OSCC_CTRL_RST;
            pend_r      <= 1'b0;
        end else if (wr_ok && wb_adr_i == `OSCC_CTRL_OFS) begin
            pend_ctrl_r <= wb_dat_i[7:0];
            pend_r      <= 1'b1;
        end else if (pend_r && scl_fall) begin
            ctrl_r <= pend_ctrl_r;
            pend_r <= 1'b0;
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            bias_r    <= `OSCC_DAC_RST;
            mod_r     <= `OSCC_DAC_RST;
            mon_fs_r  <= `OSCC_MON_FS_RST;
            imask_r   <= {`OSCC_IRQ_W{1'b0}};
            nvw_req_r <= 1'b0;
        end else begin
            nvw_req_r <= 1'b0;
            if (wr_ok) begin
                case (wb_adr_i)
                    `OSCC_BIAS_OFS:     bias_r    <= wb_dat_i[DAC_W-1:0];
                    `OSCC_MOD_OFS:      mod_r     <= wb_dat_i[DAC_W-1:0];
                    `OSCC_MON_FS_OFS:   mon_fs_r  <= wb_dat_i[MON_W-1:0];
                    `OSCC_IRQ_MASK_OFS: imask_r   <= wb_dat_i[`OSCC_IRQ_W-1:0];
                    `OSCC_NVW_OFS:      nvw_req_r <= 1'b1;
                    default:            nvw_req_r <= 1'b0;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Init and nonvolatile write timers
    // ----------------------------------------------------------------
    reg [31:0] init_cnt_r;
    reg [31:0] nvw_cnt_r;
    reg        nvw_arm_r;
    reg        flt_clr_r;
    reg        txd_d_r;

    always @(posedge clk) begin
        if (!resetn) begin
            init_cnt_r  <= 32'h00000000;
            init_done_r <= 1'b0;
            txd_d_r     <= 1'b0;
            flt_clr_r   <= 1'b0;
        end else begin
            txd_d_r   <= txd_pin;
            flt_clr_r <= txd_d_r & ~txd_pin & transmit_fault_oe;
            if (flt_clr_r) begin
                init_cnt_r  <= 32'h00000000;
                init_done_r <= 1'b0;
            end else if (!init_done_r) begin
                if (init_cnt_r >= INIT_CYC - 1) begin
                    init_done_r <= 1'b1;
                end else begin
                    init_cnt_r <= init_cnt_r + 32'h00000001;
                end
            end
        end
    end

    always @(posedge clk) begin
        if (!resetn) begin
            nvw_arm_r  <= 1'b0;
            nvw_busy_r <= 1'b0;
            nvw_cnt_r  <= 32'h00000000;
        end else if (nvw_req_r) begin
            nvw_arm_r <= 1'b1;
        end else if (nvw_arm_r && scl_fall) begin
            nvw_arm_r  <= 1'b0;
            nvw_busy_r <= 1'b1;
            nvw_cnt_r  <= 32'h00000000;
        end else if (nvw_busy_r) begin
            if (nvw_cnt_r >= NVW_CYC - 1) begin
                nvw_busy_r <= 1'b0;
            end else begin
                nvw_cnt_r <= nvw_cnt_r + 32'h00000001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Status outputs
    // ----------------------------------------------------------------
    reg [31:0] los_cnt_r;

    always @(posedge clk) begin
        if (!resetn) begin
            transmit_fault_oe      <= 1'b0;
            receive_signal_lost_oe <= 1'b0;
            rate_select_output_oe  <= 1'b0;
            los_r                  <= 1'b0;
            los_cnt_r              <= 32'h00000000;
        end else begin
            if (flt_s_r[1]) begin
                transmit_fault_oe <= 1'b1;
            end else if (flt_clr_r) begin
                transmit_fault_oe <= 1'b0;
            end
            if (los_s_r[1] == los_r) begin
                los_cnt_r <= 32'h00000000;
            end else if (los_cnt_r >= LOS_CYC - 1) begin
                los_r     <= los_s_r[1];
                los_cnt_r <= 32'h00000000;
            end else begin
                los_cnt_r <= los_cnt_r + 32'h00000001;
            end
            receive_signal_lost_oe <= los_r;
            rate_select_output_oe <= ~ctrl_r[`OSCC_CTRL_RATE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Current sinks
    // ----------------------------------------------------------------
    reg [31:0] step_cnt_r;
    reg        step_en_r;

    always @(posedge clk) begin
        if (!resetn) begin
            step_cnt_r <= 32'h00000000;
            step_en_r  <= 1'b0;
        end else if (step_cnt_r >= STEP_CYC - 1) begin
            step_cnt_r <= 32'h00000000;
            step_en_r  <= 1'b1;
        end else begin
            step_cnt_r <= step_cnt_r + 32'h00000001;
            step_en_r  <= 1'b0;
        end
    end

    // disable is pin OR soft bit OR latched fault OR init not done
    wire dac_off = txd_pin | ctrl_r[`OSCC_CTRL_TXD_BIT] | transmit_fault_oe | ~init_done_r;

    // off at once, ramp back on
    oscc_ramp #(.W(DAC_W)) u_bias (
        .clk       (clk),
        .resetn    (resetn),
        .step_en   (step_en_r),
        .disable_i (dac_off),
        .target    (bias_r),
        .level     (bias_current_sink),
        .drive_en  (bias_sink_en)
    );

    oscc_ramp #(.W(DAC_W)) u_mod (
        .clk       (clk),
        .resetn    (resetn),
        .step_en   (step_en_r),
        .disable_i (dac_off),
        .target    (mod_r),
        .level     (modulation_current_sink),
        .drive_en  (modulation_sink_en)
    );

    // ----------------------------------------------------------------
    // Monitor saturation
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (!resetn) begin
            mon_r <= {MON_W{1'b0}};
        end else if (monitor_input > {1'b0, mon_fs_r}) begin
            mon_r <= mon_fs_r;
        end else begin
            mon_r <= monitor_input[MON_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    reg txf_d_r;
    reg los_d_r;
    reg init_d_r;
    reg nvw_d_r;

    always @* begin
        ev_set = {`OSCC_IRQ_W{1'b0}};
        ev_set[`OSCC_IRQ_TXF_BIT]  = transmit_fault_oe & ~txf_d_r;
        ev_set[`OSCC_IRQ_LOS_BIT]  = los_r & ~los_d_r;
        ev_set[`OSCC_IRQ_LOSC_BIT] = ~los_r & los_d_r;
        ev_set[`OSCC_IRQ_INIT_BIT] = init_done_r & ~init_d_r;
        ev_set[`OSCC_IRQ_NVW_BIT]  = ~nvw_busy_r & nvw_d_r;
    end

    always @(posedge clk) begin
        if (!resetn) begin
            ist_r    <= {`OSCC_IRQ_W{1'b0}};
            txf_d_r  <= 1'b0;
            los_d_r  <= 1'b0;
            init_d_r <= 1'b0;
            nvw_d_r  <= 1'b0;
        end else begin
            txf_d_r  <= transmit_fault_oe;
            los_d_r  <= los_r;
            init_d_r <= init_done_r;
            nvw_d_r  <= nvw_busy_r;
            // A new event wins over a same-cycle write-one clear.
            if (wr && wb_adr_i == `OSCC_IRQ_STAT_OFS) begin
                ist_r <= (ist_r & ~wb_dat_i[`OSCC_IRQ_W-1:0]) | ev_set;
            end else begin
                ist_r <= ist_r | ev_set;
            end
        end
    end

    assign irq = |(ist_r & imask_r);

endmodule // oscc_top

/* sim/oscc_host_model.sv */
// Serial clock source standing in for the host controller.
`timescale 1ns/1ps
module oscc_host_model #(
    parameter LOW_CYC  = 30,
    parameter HIGH_CYC = 20,
    parameter PULSES   = 2
) (
    input  wire  clk,
    input  wire  frame_req,
    output logic scl,
    output logic frame_done
);
    // Fast-mode clock, still and pulled high between frames.
    // The frame's first fall follows the write and its stop.
    initial begin
        scl = 1'b1;
        frame_done = 1'b0;
        forever begin
            @(posedge clk);
            if (frame_req) begin
                repeat (PULSES) begin
                    scl <= 1'b0;
                    repeat (LOW_CYC) @(posedge clk);
                    scl <= 1'b1;
                    repeat (HIGH_CYC) @(posedge clk);
                end
                frame_done <= 1'b1;
                @(posedge clk);
                frame_done <= 1'b0;
            end
        end
    end
endmodule // oscc_host_model

/* sim/oscc_top_sva.sv */
// Concurrent checks on the port timing of the soft control block.
`timescale 1ns/1ps
module oscc_top_sva #(
    parameter DAC_W    = 8,
    parameter INIT_CYC = 50,
    parameter LOS_CYC  = 8
) (
    input wire             clk,
    input wire             resetn,
    input wire             wb_cyc_i,
    input wire             wb_stb_i,
    input wire             wb_ack_o,
    input wire             transmit_disable_pin,
    input wire             fault_in,
    input wire             signal_lost_in,
    input wire [DAC_W-1:0] bias_current_sink,
    input wire             bias_sink_en,
    input wire [DAC_W-1:0] modulation_current_sink,
    input wire             modulation_sink_en,
    input wire             transmit_fault_oe,
    input wire             receive_signal_lost_oe,
    input wire             serial_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // Saturating counters keep long waits out of the sequence operators.
    logic [7:0] boot_r, hi_r, lo_r;
    always @(posedge clk) begin
        if (!resetn) begin
            boot_r <= 8'h00;
            hi_r <= 8'h00;
            lo_r <= 8'h00;
        end else begin
            boot_r <= (boot_r == 8'hFF) ? boot_r : boot_r + 8'h01;
            hi_r <= !signal_lost_in ? 8'h00 : (hi_r == 8'hFF) ? hi_r : hi_r + 8'h01;
            lo_r <= signal_lost_in ? 8'h00 : (lo_r == 8'hFF) ? lo_r : lo_r + 8'h01;
        end
    end
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered after one cycle");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus acknowledge longer than one cycle");
    a_pin_off: assert property (transmit_disable_pin [*4] |-> !bias_sink_en && !modulation_sink_en)
        else $error("sinks still driven while the disable pin is high");
    a_off_zero: assert property (!bias_sink_en && !modulation_sink_en |-> bias_current_sink == 8'h00 && modulation_current_sink == 8'h00)
        else $error("disabled sink holds a nonzero level");
    a_ramp_step: assert property (bias_sink_en && $past(bias_sink_en) && bias_current_sink > $past(bias_current_sink) |-> bias_current_sink == $past(bias_current_sink) + 8'h01)
        else $error("bias sink rose by more than one step");
    a_ramp_start: assert property ($rose(modulation_sink_en) |-> modulation_current_sink <= 8'h01)
        else $error("modulation sink did not start its ramp from zero");
    a_fault_set: assert property ($rose(fault_in) |-> ##[1:6] transmit_fault_oe)
        else $error("fault output not set after a fault");
    a_fault_off: assert property (transmit_fault_oe |-> ##[0:2] !bias_sink_en && !modulation_sink_en)
        else $error("sinks driven while a fault is latched");
    a_los_set: assert property (hi_r >= LOS_CYC + 6 |-> receive_signal_lost_oe)
        else $error("signal loss not signalled");
    a_los_clear: assert property (lo_r >= LOS_CYC + 6 |-> !receive_signal_lost_oe)
        else $error("signal loss not withdrawn");
    a_init_busy: assert property (boot_r < INIT_CYC - 2 |-> serial_busy)
        else $error("initialization ended too early");
    a_init_done: assert property (boot_r == INIT_CYC + 4 |-> !serial_busy)
        else $error("initialization did not end in time");
    cover property ($rose(transmit_fault_oe));
    cover property ($rose(receive_signal_lost_oe));
    cover property ($rose(bias_sink_en));
endmodule // oscc_top_sva

bind oscc_top oscc_top_sva #(.DAC_W(DAC_W), .INIT_CYC(INIT_CYC), .LOS_CYC(LOS_CYC)) i_sva (
    .clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .transmit_disable_pin(transmit_disable_pin),
    .fault_in(fault_in), .signal_lost_in(signal_lost_in),
    .bias_current_sink(bias_current_sink), .bias_sink_en(bias_sink_en),
    .modulation_current_sink(modulation_current_sink),
    .modulation_sink_en(modulation_sink_en), .transmit_fault_oe(transmit_fault_oe),
    .receive_signal_lost_oe(receive_signal_lost_oe), .serial_busy(serial_busy));

/* sim/tb_top.sv */
// Self-checking bench of the soft control block.
`timescale 1ns/1ps
`include "oscc_map.vh"
module tb_top;
    logic        clk, resetn, cyc, stb, we, pin, flt, los, frm_req, frm_done, scl;
    logic        ack, irq, bias_en, mod_en, txf_oe, los_oe, rate_oe, busy;
    logic [7:0]  adr, bias, modl;
    logic [12:0] mon;
    logic [31:0] wdat, rdat, dat_o;
    int          mismatches, total_checks, cyc_cnt, i;

    oscc_top #(.INIT_CYC(50), .NVW_CYC(300), .LOS_CYC(8), .STEP_CYC(2)) i_dut (
        .clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .irq(irq), .transmit_disable_pin(pin), .fault_in(flt),
        .signal_lost_in(los), .scl_in(scl), .monitor_input(mon),
        .bias_current_sink(bias), .bias_sink_en(bias_en),
        .modulation_current_sink(modl), .modulation_sink_en(mod_en),
        .transmit_fault_oe(txf_oe), .receive_signal_lost_oe(los_oe),
        .rate_select_output_oe(rate_oe), .serial_busy(busy));
    oscc_host_model i_host (.clk(clk), .frame_req(frm_req), .scl(scl), .frame_done(frm_done));

    always #25 clk = ~clk;
    // ------------------------------------------------------------
    // Closing report and hang guard
    // ------------------------------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            mismatches++;
            end_sim;
        end
    end
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask
    // The request stays put until ack is sampled, so no wait count is assumed.
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20)
            mismatches++;
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    task frame;
        int n;
        n = 0;
        @(posedge clk);
        frm_req <= 1'b1;
        @(posedge clk);
        frm_req <= 1'b0;
        while (frm_done !== 1'b1 && n < 500) begin
            @(posedge clk);
            n++;
        end
        if (n == 500)
            mismatches++;
        tick(4);
    endtask
    task ramp(input logic [7:0] b, input logic [7:0] m);
        int n;
        logic ov;
        n = 0;
        ov = 1'b0;
        while (!(bias_en === 1'b1 && bias === b && modl === m) && n < 400) begin
            @(posedge clk);
            n++;
            if (bias > b || modl > m)
                ov = 1'b1;
        end
        chk("overshoot", ov, 1'b0);
        chk("bias_level", bias, b);
        chk("mod_level", modl, m);
    endtask
    task wait_idle;
        for (i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        {cyc, stb, we, pin, flt, los, frm_req} = 7'h00;
        adr = 8'h00;
        wdat = 32'h0;
        mon = 13'h0000;
        tick(10);
        resetn <= 1'b1;
        wb(0, `OSCC_CTRL_OFS, 0);
        chk("ctrl_reset", rdat, 32'h0);
        wb(0, `OSCC_MON_FS_OFS, 0);
        chk("fs_reset", rdat, 32'h0FFF);
        wb(0, 8'h3C, 0);
        chk("unmapped", rdat, 32'h0);
        wait_idle;
        chk("init_done", busy, 1'b0);
        chk("irq_masked", irq, 1'b0);
        wb(1, `OSCC_IRQ_MASK_OFS, 32'h1F);
        tick(1);
        chk("irq_init", irq, 1'b1);
        wb(1, `OSCC_IRQ_STAT_OFS, 32'h1F);
        tick(1);
        chk("irq_clear", irq, 1'b0);
        wb(1, `OSCC_BIAS_OFS, 32'h05);
        wb(1, `OSCC_MOD_OFS, 32'h03);
        ramp(8'h05, 8'h03);
        wb(1, `OSCC_CTRL_OFS, 32'h40);
        tick(5);
        chk("before_fall", bias_en, 1'b1);
        frame;
        chk("soft_off", {bias_en, mod_en, bias, modl}, 32'h0);
        wb(0, `OSCC_STATUS_OFS, 0);
        chk("status_off", rdat[5], 1'b1);
        wb(1, `OSCC_CTRL_OFS, 32'h00);
        frame;
        ramp(8'h05, 8'h03);
        wb(1, `OSCC_CTRL_OFS, 32'h08);
        frame;
        chk("rate_set", rate_oe, 1'b0);
        wb(1, `OSCC_CTRL_OFS, 32'h00);
        frame;
        chk("rate_clr", rate_oe, 1'b1);
        @(posedge clk) pin <= 1'b1;
        tick(6);
        chk("pin_off", {bias_en, mod_en}, 2'b00);
        @(posedge clk) pin <= 1'b0;
        ramp(8'h05, 8'h03);
        @(posedge clk) flt <= 1'b1;
        tick(8);
        chk("fault_set", txf_oe, 1'b1);
        chk("irq_fault", irq, 1'b1);
        @(posedge clk) flt <= 1'b0;
        pin <= 1'b1;
        tick(4);
        @(posedge clk) pin <= 1'b0;
        tick(6);
        chk("reinit", busy, 1'b1);
        wait_idle;
        chk("fault_reset", txf_oe, 1'b0);
        wb(1, `OSCC_IRQ_STAT_OFS, 32'h1F);
        ramp(8'h05, 8'h03);
        @(posedge clk) los <= 1'b1;
        tick(20);
        chk("los_set", los_oe, 1'b1);
        @(posedge clk) los <= 1'b0;
        tick(20);
        chk("los_clear", los_oe, 1'b0);
        wb(0, `OSCC_IRQ_STAT_OFS, 0);
        chk("irq_los", rdat[2:1], 2'b11);
        wb(1, `OSCC_MON_FS_OFS, 32'h100);
        @(posedge clk) mon <= 13'h1FFF;
        tick(4);
        wb(0, `OSCC_MON_OFS, 0);
        chk("mon_sat", rdat, 32'h100);
        @(posedge clk) mon <= 13'h0050;
        tick(4);
        wb(0, `OSCC_MON_OFS, 0);
        chk("mon_pass", rdat, 32'h50);
        wb(1, `OSCC_NVW_OFS, 32'h1);
        tick(5);
        chk("nvw_wait_stop", busy, 1'b0);
        frame;
        chk("nvw_busy", busy, 1'b1);
        wb(1, `OSCC_CTRL_OFS, 32'h08);
        frame;
        wb(0, `OSCC_CTRL_OFS, 0);
        chk("nvw_ignore", rdat, 32'h0);
        wait_idle;
        chk("nvw_done", busy, 1'b0);
        chk("rate_kept", rate_oe, 1'b1);
        wb(0, `OSCC_IRQ_STAT_OFS, 0);
        chk("irq_nvw", rdat[4], 1'b1);
        end_sim;
    end
endmodule // tb_top
